// file: simb_pkg.sv
package simb_pkg;

   // ---------------------------------------------------------------
   // Geometry
   // ---------------------------------------------------------------
   localparam int ROW_W     = 13;
   localparam int COL_W     = 10;
   localparam int BANK_W    = 2;
   localparam int NUM_BANKS = 4;
   localparam int MODE_W    = 12;
   localparam int ADDR_W    = 13;
   localparam int AP_BIT    = 10;

   // ---------------------------------------------------------------
   // Mode field positions and reset value
   // ---------------------------------------------------------------
   localparam int BL_LSB    = 0;
   localparam int BT_BIT    = 3;
   localparam int RL_LSB    = 4;
   localparam int OPM_LSB   = 7;
   localparam int WB_BIT    = 9;
   localparam logic [MODE_W-1:0] MODE_RESET = 12'h000;

   // ---------------------------------------------------------------
   // Burst length and latency codes
   // ---------------------------------------------------------------
   localparam logic [2:0] BL_1    = 3'h0;
   localparam logic [2:0] BL_2    = 3'h1;
   localparam logic [2:0] BL_4    = 3'h2;
   localparam logic [2:0] BL_8    = 3'h3;
   localparam logic [2:0] BL_FULL = 3'h7;
   localparam logic [2:0] RL_2    = 3'h2;
   localparam logic [2:0] RL_3    = 3'h3;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   localparam int AP_TIME_NS    = 20;
   localparam int AP_CYCLES     = (AP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   typedef enum logic [3:0] {
      CMD_INHIBIT, CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE,
      CMD_TERMINATE, CMD_PRECHARGE, CMD_REFRESH, CMD_LOAD_MODE
   } simb_cmd_t;

   typedef struct packed {
      logic              cs_n;
      logic              ras_n;
      logic              cas_n;
      logic              we_n;
      logic              bank_select_high;
      logic              bank_select_low;
      logic [ADDR_W-1:0] addr;
   } simb_pins_t;

   typedef struct packed {
      logic              valid;
      logic              write;
      logic              first;
      logic [BANK_W-1:0] bank;
      logic [ROW_W-1:0]  row;
      logic [COL_W-1:0]  col;
   } simb_access_t;

endpackage

// file: simb_core.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - All command, address and data pins are sampled on the rising clock edge.
// - Activate takes the bank-select pair as bank and address lines as row.
// - Read or write takes column address lines 0-9 as burst start column.
// - Four banks, each 8192 rows of 1024 sixteen-bit columns.
// - A new column command is accepted every clock, restarting the burst.
// - Auto precharge closes the row self-timed once a fixed-length burst finishes; full-row bursts never trigger it.
// - Mode loaded before use; held until reprogrammed or power lost.
// - Mode bits: length, type, latency, operating mode, write burst; 10-11 reserved.
// - Lengths 1,2,4,8 for both types; full row only sequential.
// - Full-row bursts are cut short by burst terminate.
// - Bursts of 2,4,8 take block from upper bits, start from lower.
// - Burst wraps to the start of its block, never crossing it.
// - Sequential order increments the in-block offset modulo burst length.
// - Interleaved order is start offset XOR beat count.
// - Full-row burst starts at given column, increments and wraps at row end.
// - Length one accesses only the given column; type bit ignored.
// - First read data after programmed two or three clocks, drive one earlier.
// - Write burst bit set makes writes single-location; reads keep length.
// - Commands decoded from chip select, row, column strobes and write enable.
module simb_core (
   input  wire logic                           clk_sys,
   input  wire logic                           rst_n,
   input  wire simb_pkg::simb_pins_t           pins_in,
   output simb_pkg::simb_access_t              access_out,
   output logic                                read_data_valid,
   output logic                                dq_oe_n,
   output logic [simb_pkg::NUM_BANKS-1:0]      bank_open,
   output logic [simb_pkg::MODE_W-1:0]         operating_mode_settings
);

   // ---------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------
   function automatic simb_pkg::simb_cmd_t decode_cmd(input simb_pkg::simb_pins_t p);
      simb_pkg::simb_cmd_t c;
      c = simb_pkg::CMD_NOP;
      if (p.cs_n) begin
         c = simb_pkg::CMD_INHIBIT;
      end else begin
         case ({p.ras_n, p.cas_n, p.we_n})
            3'h7: c = simb_pkg::CMD_NOP;
            3'h3: c = simb_pkg::CMD_ACTIVE;
            3'h5: c = simb_pkg::CMD_READ;
            3'h4: c = simb_pkg::CMD_WRITE;
            3'h6: c = simb_pkg::CMD_TERMINATE;
            3'h2: c = simb_pkg::CMD_PRECHARGE;
            3'h1: c = simb_pkg::CMD_REFRESH;
            3'h0: c = simb_pkg::CMD_LOAD_MODE;
            default: c = simb_pkg::CMD_NOP;
         endcase
      end
      return c;
   endfunction

   function automatic logic [simb_pkg::COL_W-1:0] len_mask(input logic [2:0] bl);
      logic [simb_pkg::COL_W-1:0] m;
      m = 10'h000;
      case (bl)
         simb_pkg::BL_2:    m = 10'h001;
         simb_pkg::BL_4:    m = 10'h003;
         simb_pkg::BL_8:    m = 10'h007;
         simb_pkg::BL_FULL: m = 10'h3FF;
         default:           m = 10'h000;
      endcase
      return m;
   endfunction

   function automatic logic [simb_pkg::COL_W-1:0] beat_col(
      input logic [simb_pkg::COL_W-1:0] start,
      input logic [simb_pkg::COL_W-1:0] beat,
      input logic [2:0]                 bl,
      input logic                       interleave
   );
      logic [simb_pkg::COL_W-1:0] m;
      logic [simb_pkg::COL_W-1:0] off;
      m = len_mask(bl);
      if (interleave && bl != simb_pkg::BL_FULL) begin
         off = (start ^ beat) & m;
      end else begin
         off = (start + beat) & m;
      end
      return (start & ~m) | off;
   endfunction

   // ---------------------------------------------------------------
   // Pin sampling
   // ---------------------------------------------------------------
   simb_pkg::simb_pins_t pins_s1_reg;
   simb_pkg::simb_pins_t pins_reg;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pins_s1_reg <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
         pins_reg    <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
      end else begin
         pins_s1_reg <= pins_in;
         pins_reg    <= pins_s1_reg;
      end
   end

   simb_pkg::simb_cmd_t         cmd;
   logic [simb_pkg::BANK_W-1:0] cmd_bank;
   logic                        col_cmd;

   assign cmd      = decode_cmd(pins_reg);
   assign cmd_bank = {pins_reg.bank_select_high, pins_reg.bank_select_low};
   assign col_cmd  = (cmd == simb_pkg::CMD_READ) || (cmd == simb_pkg::CMD_WRITE);

   // ---------------------------------------------------------------
   // Mode register
   // ---------------------------------------------------------------
   logic [simb_pkg::MODE_W-1:0] mode_reg;
   logic [2:0]                  mode_bl;
   logic                        mode_il;
   logic [2:0]                  mode_rl;
   logic                        mode_wb;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         mode_reg <= simb_pkg::MODE_RESET;
      end else if (cmd == simb_pkg::CMD_LOAD_MODE) begin
         mode_reg <= pins_reg.addr[simb_pkg::MODE_W-1:0];
      end
   end

   assign mode_bl = mode_reg[simb_pkg::BL_LSB +: 3];
   assign mode_il = mode_reg[simb_pkg::BT_BIT];
   assign mode_rl = mode_reg[simb_pkg::RL_LSB +: 3];
   assign mode_wb = mode_reg[simb_pkg::WB_BIT];

   // ---------------------------------------------------------------
   // Burst engine
   // ---------------------------------------------------------------
   logic                        burst_on_reg;
   logic [simb_pkg::COL_W-1:0]  beat_reg;
   logic [simb_pkg::COL_W-1:0]  start_col_reg;
   logic [simb_pkg::BANK_W-1:0] burst_bank_reg;
   logic                        burst_wr_reg;
   logic                        burst_ap_reg;
   logic [2:0]                  burst_bl_reg;

   logic                        now_valid;
   logic [simb_pkg::COL_W-1:0]  now_beat;
   logic [simb_pkg::COL_W-1:0]  now_start;
   logic [2:0]                  now_bl;
   logic                        now_wr;
   logic                        now_ap;
   logic [simb_pkg::BANK_W-1:0] now_bank;
   logic                        now_last;
   logic [simb_pkg::NUM_BANKS-1:0] ap_fire;

   always_comb begin
      now_valid = 1'b0;
      now_beat  = 10'h000;
      now_start = start_col_reg;
      now_bl    = burst_bl_reg;
      now_wr    = burst_wr_reg;
      now_ap    = burst_ap_reg;
      now_bank  = burst_bank_reg;
      if (col_cmd) begin
         now_valid = 1'b1;
         now_start = pins_reg.addr[simb_pkg::COL_W-1:0];
         now_wr    = (cmd == simb_pkg::CMD_WRITE);
         now_ap    = pins_reg.addr[simb_pkg::AP_BIT];
         now_bank  = cmd_bank;
         now_bl    = (now_wr && mode_wb) ? simb_pkg::BL_1 : mode_bl;
      end else if (burst_on_reg && cmd != simb_pkg::CMD_TERMINATE) begin
         now_valid = 1'b1;
         now_beat  = beat_reg;
      end
   end

   assign now_last = (now_bl != simb_pkg::BL_FULL) && (now_beat == len_mask(now_bl));

   always_comb begin
      ap_fire = '0;
      if (now_valid && now_last && now_ap) begin
         ap_fire[now_bank] = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         burst_on_reg   <= 1'b0;
         beat_reg       <= 10'h000;
         start_col_reg  <= 10'h000;
         burst_bank_reg <= 2'h0;
         burst_wr_reg   <= 1'b0;
         burst_ap_reg   <= 1'b0;
         burst_bl_reg   <= simb_pkg::BL_1;
      end else begin
         burst_on_reg   <= now_valid && !now_last;
         beat_reg       <= now_beat + 10'h001;
         start_col_reg  <= now_start;
         burst_bank_reg <= now_bank;
         burst_wr_reg   <= now_wr;
         burst_ap_reg   <= now_ap;
         burst_bl_reg   <= now_bl;
      end
   end

   // ---------------------------------------------------------------
   // Bank and row state
   // ---------------------------------------------------------------
   logic [simb_pkg::ROW_W-1:0] row_reg [simb_pkg::NUM_BANKS];
   logic [simb_pkg::NUM_BANKS-1:0] open_reg;
   logic [2:0] ap_cnt_reg [simb_pkg::NUM_BANKS];

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         open_reg <= '0;
         for (int b = 0; b < simb_pkg::NUM_BANKS; b++) begin
            row_reg[b]    <= 13'h0000;
            ap_cnt_reg[b] <= 3'h0;
         end
      end else begin
         for (int b = 0; b < simb_pkg::NUM_BANKS; b++) begin
            if (ap_fire[b]) begin
               ap_cnt_reg[b] <= 3'(simb_pkg::AP_CYCLES);
            end else if (ap_cnt_reg[b] != 3'h0) begin
               ap_cnt_reg[b] <= ap_cnt_reg[b] - 3'h1;
               if (ap_cnt_reg[b] == 3'h1) begin
                  open_reg[b] <= 1'b0;
               end
            end
            if (cmd == simb_pkg::CMD_ACTIVE && cmd_bank == 2'(b)) begin
               open_reg[b] <= 1'b1;
               row_reg[b]  <= pins_reg.addr[simb_pkg::ROW_W-1:0];
            end else if (cmd == simb_pkg::CMD_PRECHARGE &&
                         (pins_reg.addr[simb_pkg::AP_BIT] || cmd_bank == 2'(b))) begin
               open_reg[b] <= 1'b0;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Access and read data timing
   // ---------------------------------------------------------------
   simb_pkg::simb_access_t acc_reg;
   logic [1:0] rd_sh_reg;
   logic       valid_reg;
   logic       oe_n_reg;
   logic       rd_now;
   logic       valid_next;
   logic       lead_next;

   assign rd_now     = now_valid && !now_wr;
   assign valid_next = (mode_rl == simb_pkg::RL_2) ? rd_sh_reg[0] : rd_sh_reg[1];
   assign lead_next  = (mode_rl == simb_pkg::RL_2) ? rd_now : rd_sh_reg[0];

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         acc_reg <= '0;
      end else begin
         acc_reg.valid <= now_valid;
         acc_reg.write <= now_wr;
         acc_reg.first <= col_cmd;
         acc_reg.bank  <= now_bank;
         acc_reg.row   <= row_reg[now_bank];
         acc_reg.col   <= beat_col(now_start, now_beat, now_bl, mode_il);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rd_sh_reg <= 2'h0;
         valid_reg <= 1'b0;
         oe_n_reg  <= 1'b1;
      end else begin
         rd_sh_reg <= {rd_sh_reg[0], rd_now};
         valid_reg <= valid_next;
         oe_n_reg  <= !(lead_next || valid_next);
      end
   end

   assign access_out              = acc_reg;
   assign read_data_valid         = valid_reg;
   assign dq_oe_n                 = oe_n_reg;
   assign bank_open               = open_reg;
   assign operating_mode_settings = mode_reg;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   sequence s_col_issue;
      col_cmd;
   endsequence

   sequence s_single_then_idle;
      s_col_issue ##1 !col_cmd;
   endsequence

   a_active_opens_row: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (cmd == simb_pkg::CMD_ACTIVE && cmd_bank == 2'h1) |=>
      open_reg[1] && row_reg[1] == $past(pins_reg.addr))
      else $error("activate did not open the row");

   a_col_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_col_issue |=> acc_reg.valid && acc_reg.first && acc_reg.col == $past(pins_reg.addr[9:0]))
      else $error("burst did not start at the given column");

   a_mode_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (cmd == simb_pkg::CMD_LOAD_MODE) |=> mode_reg == $past(pins_reg.addr[11:0]))
      else $error("mode register not loaded");

   a_mode_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (cmd != simb_pkg::CMD_LOAD_MODE) |=> $stable(mode_reg))
      else $error("mode register changed without a load");

   a_single_beat: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (mode_bl == simb_pkg::BL_1 && cmd != simb_pkg::CMD_LOAD_MODE) throughout
      s_single_then_idle |=> !acc_reg.valid)
      else $error("length one burst issued a second beat");

   a_write_single: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (cmd == simb_pkg::CMD_WRITE && mode_wb) ##1 !col_cmd |=> !acc_reg.valid)
      else $error("single-location write ran on");

   a_block_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (acc_reg.valid && burst_bl_reg == simb_pkg::BL_8) |->
      acc_reg.col[9:3] == start_col_reg[9:3])
      else $error("burst crossed its block");

   a_seq_order: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (acc_reg.valid && !acc_reg.first && !mode_il && burst_bl_reg == simb_pkg::BL_4
       && $past(burst_bl_reg) == simb_pkg::BL_4) |->
      acc_reg.col[1:0] == 2'($past(acc_reg.col[1:0]) + 2'h1))
      else $error("sequential order broken");

   a_read_latency: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (cmd == simb_pkg::CMD_READ && mode_rl == simb_pkg::RL_2) |->
      ##1 !oe_n_reg ##1 valid_reg)
      else $error("read data not on time");

   a_auto_precharge: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ap_fire[2] && cmd != simb_pkg::CMD_ACTIVE) |-> ##[1:8] !open_reg[2])
      else $error("auto precharge did not close the bank");

endmodule

`default_nettype wire

// file: simb_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Controller model driving the command pins
// ----------------------------------------------------------------
module simb_ctrl_model #(
   parameter int STARTUP_CYCLES = 20000,
   parameter int GAP_CYCLES     = 3
) (
   input  wire logic                clk_sys,
   output var simb_pkg::simb_pins_t pins
);
   int edge_n = 0;

   always @(posedge clk_sys) begin
      edge_n <= edge_n + 1;
   end

   initial begin
      pins = simb_pkg::simb_pins_t'({4'hF, 15'h0000});
   end

   task automatic cmd(input logic [3:0] code, input logic [1:0] bk, input logic [12:0] a);
      @(posedge clk_sys);
      pins <= simb_pkg::simb_pins_t'({code, bk, a});
   endtask

   task automatic idle(input int n, input logic [3:0] code = 4'h7);
      repeat (n) begin
         @(posedge clk_sys);
         pins <= simb_pkg::simb_pins_t'({code, ~pins[14:0]});
      end
   endtask

   task automatic power_up(input logic [31:0] r);
      idle(STARTUP_CYCLES / 2, 4'hF);
      idle(STARTUP_CYCLES / 2);
      cmd(4'h2, r[1:0], {r[4:3], 1'b1, r[14:5]});
      idle(GAP_CYCLES);
      repeat (2) begin
         cmd(4'h1, r[16:15], r[29:17]);
         idle(GAP_CYCLES);
      end
   endtask

   task automatic load_mode(input logic [11:0] m, input logic [31:0] r);
      cmd(4'h2, r[1:0], {r[4:3], 1'b1, r[14:5]});
      idle(GAP_CYCLES);
      cmd(4'h0, r[16:15], {1'b0, m & 12'hE7F});
   endtask
endmodule
`default_nettype wire

// file: sdram_init_mode_burst_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sdram_init_mode_burst_tb;
   logic                           clk_sys = 1'b0;
   logic                           rst_n   = 1'b0;
   simb_pkg::simb_pins_t           pins;
   simb_pkg::simb_access_t         access_out;
   logic                           read_data_valid;
   logic                           dq_oe_n;
   logic [simb_pkg::NUM_BANKS-1:0] bank_open;
   logic [simb_pkg::MODE_W-1:0]    operating_mode_settings;
   int                             failures = 0;
   int                             n_checks = 0;
   int                             last_beat;
   logic [31:0]                    lfsr_q   = 32'h320FBDB1;
   logic [11:0]                    mode_exp = 12'h000;
   logic [12:0]                    row_exp [4];
   simb_pkg::simb_access_t         exp_acc [int];
   bit                             exp_rdv [int];
   logic [2:0]                     codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};

   always #2.5 clk_sys = ~clk_sys;

   simb_ctrl_model u_simb_ctrl_model (
      .clk_sys (clk_sys),
      .pins    (pins)
   );

   simb_core u_simb_core (
      .clk_sys                 (clk_sys),
      .rst_n                   (rst_n),
      .pins_in                 (pins),
      .access_out              (access_out),
      .read_data_valid         (read_data_valid),
      .dq_oe_n                 (dq_oe_n),
      .bank_open               (bank_open),
      .operating_mode_settings (operating_mode_settings)
   );

   // ----------------------------------------------------------------
   // Reference model and compares
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic cmp_val(input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch at %0t: expected %h got %h", $time, e, g);
      end
   endtask

   task automatic cmp_acc(input simb_pkg::simb_access_t e, input simb_pkg::simb_access_t g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch at %0t: expected %h got %h", $time, e, g);
      end
   endtask

   always @(negedge clk_sys) begin
      int t;
      t = u_simb_ctrl_model.edge_n;
      cmp_val(32'(exp_acc.exists(t)), 32'(access_out.valid));
      if (exp_acc.exists(t)) begin
         cmp_acc(exp_acc[t], access_out);
      end
      cmp_val(32'(exp_rdv.exists(t)), 32'(read_data_valid));
      cmp_val(32'(!(exp_rdv.exists(t) || exp_rdv.exists(t + 1))), 32'(dq_oe_n));
   end

   task automatic wait_to(input int t);
      while (u_simb_ctrl_model.edge_n < t) begin
         @(negedge clk_sys);
      end
   endtask

   task automatic purge(input int t, input int lat);
      for (int i = t; i < t + 1100; i++) begin
         if (exp_acc.exists(i)) begin
            exp_acc.delete(i);
         end
         if (exp_rdv.exists(i + lat - 1)) begin
            exp_rdv.delete(i + lat - 1);
         end
      end
   endtask

   task automatic col_cmd(input bit wr, input bit ap, input logic [1:0] bk, input logic [9:0] st);
      int         e;
      int         n;
      int         lat;
      logic [9:0] m;
      logic [9:0] c;
      case (mode_exp[2:0])
         3'h1: n = 2;
         3'h2: n = 4;
         3'h3: n = 8;
         3'h7: n = 1024;
         default: n = 1;
      endcase
      if (wr && mode_exp[9]) begin
         n = 1;
      end
      lat = (mode_exp[6:4] == 3'h2) ? 2 : 3;
      m = 10'(n - 1);
      u_simb_ctrl_model.cmd(wr ? 4'h4 : 4'h5, bk, {2'h0, ap, st});
      e = u_simb_ctrl_model.edge_n + 1;
      purge(e + 3, lat);
      for (int k = 0; k < n; k++) begin
         if (mode_exp[3] && n < 1024) begin
            c = (st & ~m) | ((st ^ 10'(k)) & m);
         end else begin
            c = (st & ~m) | ((st + 10'(k)) & m);
         end
         exp_acc[e + 3 + k] = '{1'b1, wr, k == 0, bk, row_exp[bk], c};
         if (!wr) begin
            exp_rdv[e + 2 + k + lat] = 1'b1;
         end
      end
      last_beat = e + 2 + n;
   endtask

   task automatic set_mode(input logic [11:0] m);
      int e;
      lfsr_q = lfsr_next(lfsr_q);
      u_simb_ctrl_model.load_mode(m, lfsr_q);
      e = u_simb_ctrl_model.edge_n + 1;
      mode_exp = m;
      u_simb_ctrl_model.idle(2);
      wait_to(e + 3);
      cmp_val(32'(m), 32'(operating_mode_settings));
   endtask

   task automatic activate(input logic [1:0] bk);
      int e;
      lfsr_q = lfsr_next(lfsr_q);
      u_simb_ctrl_model.cmd(4'h3, bk, lfsr_q[12:0]);
      e = u_simb_ctrl_model.edge_n + 1;
      row_exp[bk] = lfsr_q[12:0];
      u_simb_ctrl_model.idle(1);
      wait_to(e + 3);
      cmp_val(32'h1, 32'(bank_open[bk]));
   endtask

   task automatic conclude();
      if (failures == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      logic [9:0] st;
      logic [1:0] bk;
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      u_simb_ctrl_model.power_up(lfsr_q);
      set_mode(12'h022);
      for (int b = 0; b < 4; b++) begin
         activate(2'(b));
      end
      foreach (codes[i]) begin
         for (int bt = 0; bt < 2; bt++) begin
            for (int lt = 2; lt < 4; lt++) begin
               if (!(bt == 1 && codes[i] == 3'h7)) begin
                  set_mode({5'h00, 3'(lt), 1'(bt), codes[i]});
                  lfsr_q = lfsr_next(lfsr_q);
                  bk = lfsr_q[21:20];
                  st = (codes[i] == 3'h7) ? {7'h7F, lfsr_q[2:0]} : lfsr_q[9:0];
                  activate(bk);
                  col_cmd(1'b0, 1'b0, bk, st);
                  col_cmd(1'b0, 1'b0, bk, st ^ 10'h005);
                  u_simb_ctrl_model.idle(1);
                  col_cmd(1'b1, 1'b0, bk, st ^ 10'h002);
                  u_simb_ctrl_model.idle(9);
                  if (codes[i] == 3'h7) begin
                     u_simb_ctrl_model.cmd(4'h6, bk, lfsr_q[28:16]);
                     purge(u_simb_ctrl_model.edge_n + 4, 3);
                  end
                  u_simb_ctrl_model.idle(14);
               end
            end
         end
      end
      set_mode(12'h232);
      activate(2'h1);
      col_cmd(1'b1, 1'b0, 2'h1, 10'h00D);
      u_simb_ctrl_model.idle(3);
      col_cmd(1'b0, 1'b0, 2'h1, 10'h00D);
      u_simb_ctrl_model.idle(12);
      set_mode(12'h022);
      activate(2'h2);
      col_cmd(1'b0, 1'b1, 2'h2, 10'h1F6);
      u_simb_ctrl_model.idle(1);
      wait_to(last_beat + 3);
      cmp_val(32'h1, 32'(bank_open[2]));
      wait_to(last_beat + 4);
      cmp_val(32'h0, 32'(bank_open[2]));
      u_simb_ctrl_model.idle(8);
      cmp_val(32'(mode_exp), 32'(operating_mode_settings));
      conclude();
   end

   initial begin
      #400000;
      failures++;
      conclude();
   end
endmodule
`default_nettype wire
